//--- src/crs_cal_engine.v
`timescale 1ns/1ns
`default_nettype none
`include "crs_regs.vh"
// Calibration sequencer: clear, optional foreground pass, optional background loop
module crs_cal_engine #(
  parameter FG_CYCLES = `CRS_FG_CYCLES
) (
  input wire mclk_in,
  input wire rst_in,
  input wire run_en_in,
  input wire fg_on_in,
  input wire bg_on_in,
  input wire bg_halt_in,
  output reg fg_finished_out,
  output reg bg_stopped_out,
  output reg fg_active_out,
  output reg bg_active_out,
  output reg clearing_out
);
  localparam S_HOLD = 5'b00001;
  localparam S_CLEAR = 5'b00010;
  localparam S_FG = 5'b00100;
  localparam S_BG = 5'b01000;
  localparam S_IDLE = 5'b10000;
  reg [4:0] state_ff;
  reg [4:0] nxt_state;
  reg [15:0] cnt_ff;
  reg [15:0] nxt_cnt;
  always @* begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff + 16'h0001;
    case (state_ff)
      S_HOLD: begin
        nxt_cnt = 16'h0000;
        if (run_en_in) nxt_state = S_CLEAR;
      end
      S_CLEAR: if (cnt_ff == `CRS_CLR_CYCLES - 1) begin
        nxt_cnt = 16'h0000;
        nxt_state = fg_on_in ? S_FG : (bg_on_in ? S_BG : S_IDLE);
      end
      S_FG: if (cnt_ff == FG_CYCLES - 1) begin
        nxt_cnt = 16'h0000;
        nxt_state = bg_on_in ? S_BG : S_IDLE;
      end
      S_BG: nxt_cnt = 16'h0000;
      S_IDLE: nxt_cnt = 16'h0000;
      default: nxt_state = S_HOLD;
    endcase
    if (!run_en_in) nxt_state = S_HOLD;
  end
  always @(posedge mclk_in) begin
    if (rst_in) begin
      state_ff <= S_HOLD;
      cnt_ff <= 16'h0000;
      fg_finished_out <= 1'b0;
      bg_stopped_out <= 1'b0;
      fg_active_out <= 1'b0;
      bg_active_out <= 1'b0;
      clearing_out <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      fg_active_out <= (nxt_state == S_FG);
      bg_active_out <= (nxt_state == S_BG) && !bg_halt_in;
      clearing_out <= (nxt_state == S_CLEAR);
      if (nxt_state == S_HOLD || nxt_state == S_CLEAR) fg_finished_out <= 1'b0;
      else if (state_ff == S_FG && nxt_state != S_FG) fg_finished_out <= 1'b1;
      if (nxt_state == S_IDLE) bg_stopped_out <= 1'b1;
      else if (nxt_state == S_BG) bg_stopped_out <= bg_halt_in;
      else bg_stopped_out <= 1'b0;
    end
  end
endmodule // crs_cal_engine
`default_nettype wire

//--- src/crs_regs.vh
// Contract
// - Dual mode: swap bit 4 crosses inputs when 1; ignored in single mode.
// - Single mode: select 1 picks input A, 2 input B; 0,3 reserved.
// - Calibration enable bit 0, reset 1; low holds calibration in reset.
// - Clearing calibration enable also resets digital and serial clock dividers.
// - Change calibration setup only while disabled; re-enabling reruns calibration.
// - Setup bit 4 enables offset smoothing; reset value off.
// - Setup bit 3 enables background offset cal, only with background cal.
// - Setup bit 2 enables foreground offset cal, only with foreground cal.
// - Setup bit 1 enables background calibration; default off.
// - Setup bit 0, reset 1: reset values, then run or skip foreground pass.
// - Status register read-only; bit 1 background stopped, bit 0 foreground done.
// - Foreground done bit rises when foreground calibration completes.
// - Stopped bit set on halt, cleared on resume; set after foreground if no background.
`ifndef CRS_REGS_VH
`define CRS_REGS_VH
`define CRS_IDX_ROUTE 10'h060
`define CRS_IDX_RUN 10'h061
`define CRS_IDX_SETUP 10'h062
`define CRS_IDX_PROG 10'h06A
`define CRS_IDX_OSC0 10'h097
`define CRS_IDX_OSC1 10'h098
`define CRS_IDX_OADJ_LO 10'h094
`define CRS_IDX_OADJ_HI 10'h095
`define CRS_IDX_IRQ_STAT 10'h0F0
`define CRS_IDX_IRQ_MASK 10'h0F1
`define CRS_IDX_LINK 10'h0F2
`define CRS_RST_ROUTE 8'h01
`define CRS_RST_RUN 8'h01
`define CRS_RST_SETUP 8'h01
`define CRS_RST_OSC0 8'h00
`define CRS_RST_OSC1 8'h33
`define CRS_BIT_SWAP 4
`define CRS_BIT_SMOOTH 4
`define CRS_BIT_BGOS 3
`define CRS_BIT_FGOS 2
`define CRS_BIT_BG 1
`define CRS_BIT_FG 0
`define CRS_BIT_STOPPED 1
`define CRS_BIT_DONE 0
`define CRS_SEL_A 2'h1
`define CRS_SEL_B 2'h2
`define CRS_FG_TIME_NS 40000
`define CRS_CLK_NS 40
`define CRS_FG_CYCLES (`CRS_FG_TIME_NS / `CRS_CLK_NS)
`define CRS_CLR_CYCLES 4
`endif

//--- src/crs_top.v
// The Wishbone register port was decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "crs_regs.vh"
module crs_top #(
  parameter FG_CYCLES = `CRS_FG_CYCLES
) (
  // Clock and reset
  input wire mclk_in,
  input wire rst_in,
  // Wishbone slave
  input wire wb_cyc_in,
  input wire wb_stb_in,
  input wire wb_we_in,
  input wire [11:0] wb_adr_in,
  input wire [3:0] wb_sel_in,
  input wire [31:0] wb_dat_in,
  output reg [31:0] wb_dat_out,
  output reg wb_ack_out,
  // Mode and halt request from elsewhere in the device
  input wire single_mode_in,
  input wire bg_halt_in,
  // Routing controls
  output reg chan_a_takes_b_out,
  output reg chan_b_takes_a_out,
  output reg single_uses_b_out,
  output reg single_sel_bad_out,
  // Calibration controls and serial link enable
  output reg cal_hold_out,
  output reg divider_reset_out,
  output reg fg_offset_run_out,
  output reg bg_offset_run_out,
  output reg smoothing_on_out,
  output reg fg_active_out,
  output reg bg_active_out,
  output reg [15:0] offset_adjust_out,
  output reg [7:0] smooth_ctl0_out,
  output reg [7:0] smooth_ctl1_out,
  output reg serial_link_enable_out,
  // Interrupt
  output reg irq_out
);
  reg [7:0] route_ff;
  reg [7:0] run_ff;
  reg [7:0] setup_ff;
  reg [7:0] osc0_ff;
  reg [7:0] osc1_ff;
  reg [15:0] oadj_ff;
  reg [1:0] stat_ff;
  reg [1:0] mask_ff;
  reg link_ff;
  reg [1:0] last_prog_ff;
  reg [31:0] nxt_rdata;
  wire [9:0] idx = wb_adr_in[11:2];
  wire req = wb_cyc_in && wb_stb_in && !wb_ack_out;
  wire wr = req && wb_we_in && wb_sel_in[0];
  wire rd = req && !wb_we_in;
  wire eng_done;
  wire eng_stopped;
  wire eng_fg;
  wire eng_bg;
  wire eng_clr;
  wire [1:0] prog = {eng_stopped, eng_done};
  wire [1:0] rise = prog & ~last_prog_ff;
  wire rd_stat = rd && idx == `CRS_IDX_IRQ_STAT;
  wire [1:0] nxt_stat;
  // Per event bit: a new edge beats the read-clear
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_evt
      assign nxt_stat[g] = rise[g] | (stat_ff[g] & !rd_stat);
    end
  endgenerate
  crs_cal_engine #(.FG_CYCLES(FG_CYCLES)) u_eng (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .run_en_in(run_ff[0]),
    .fg_on_in(setup_ff[`CRS_BIT_FG]),
    .bg_on_in(setup_ff[`CRS_BIT_BG]),
    .bg_halt_in(bg_halt_in),
    .fg_finished_out(eng_done),
    .bg_stopped_out(eng_stopped),
    .fg_active_out(eng_fg),
    .bg_active_out(eng_bg),
    .clearing_out(eng_clr)
  );
  always @* begin
    nxt_rdata = 32'h00000000;
    case (idx)
      `CRS_IDX_ROUTE: nxt_rdata[7:0] = route_ff;
      `CRS_IDX_RUN: nxt_rdata[7:0] = run_ff;
      `CRS_IDX_SETUP: nxt_rdata[7:0] = setup_ff;
      `CRS_IDX_PROG: nxt_rdata[1:0] = prog;
      `CRS_IDX_OSC0: nxt_rdata[7:0] = osc0_ff;
      `CRS_IDX_OSC1: nxt_rdata[7:0] = osc1_ff;
      `CRS_IDX_OADJ_LO: nxt_rdata[7:0] = oadj_ff[7:0];
      `CRS_IDX_OADJ_HI: nxt_rdata[7:0] = oadj_ff[15:8];
      `CRS_IDX_IRQ_STAT: nxt_rdata[1:0] = stat_ff;
      `CRS_IDX_IRQ_MASK: nxt_rdata[1:0] = mask_ff;
      `CRS_IDX_LINK: nxt_rdata[0] = link_ff;
      default: nxt_rdata = 32'h00000000;
    endcase
  end
  always @(posedge mclk_in) begin
    if (rst_in) begin
      route_ff <= `CRS_RST_ROUTE;
      run_ff <= `CRS_RST_RUN;
      setup_ff <= `CRS_RST_SETUP;
      osc0_ff <= `CRS_RST_OSC0;
      osc1_ff <= `CRS_RST_OSC1;
      oadj_ff <= 16'h0000;
      mask_ff <= 2'h0;
      link_ff <= 1'b0;
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h00000000;
    end else begin
      wb_ack_out <= req;
      if (rd) wb_dat_out <= nxt_rdata;
      if (wr) begin
        case (idx)
          `CRS_IDX_ROUTE: route_ff <= wb_dat_in[7:0];
          `CRS_IDX_RUN: run_ff <= wb_dat_in[7:0];
          // Taken whenever written; software keeps it to the disabled window
          `CRS_IDX_SETUP: setup_ff <= wb_dat_in[7:0];
          `CRS_IDX_OSC0: osc0_ff <= wb_dat_in[7:0];
          `CRS_IDX_OSC1: osc1_ff <= wb_dat_in[7:0];
          `CRS_IDX_OADJ_LO: oadj_ff[7:0] <= wb_dat_in[7:0];
          `CRS_IDX_OADJ_HI: oadj_ff[15:8] <= wb_dat_in[7:0];
          `CRS_IDX_IRQ_MASK: mask_ff <= wb_dat_in[1:0];
          `CRS_IDX_LINK: link_ff <= wb_dat_in[0];
          default: ; // Status register writes dropped
        endcase
      end
    end
  end
  // Sticky events; a new edge beats the read-clear
  always @(posedge mclk_in) begin
    if (rst_in) begin
      stat_ff <= 2'h0;
      last_prog_ff <= 2'h0;
      irq_out <= 1'b0;
    end else begin
      last_prog_ff <= prog;
      stat_ff <= nxt_stat;
      // Follows the status it will hold, so a surviving edge keeps irq up
      irq_out <= |(nxt_stat & mask_ff);
    end
  end
  always @(posedge mclk_in) begin
    if (rst_in) begin
      chan_a_takes_b_out <= 1'b0;
      chan_b_takes_a_out <= 1'b0;
      single_uses_b_out <= 1'b0;
      single_sel_bad_out <= 1'b0;
      cal_hold_out <= 1'b0;
      divider_reset_out <= 1'b0;
      fg_offset_run_out <= 1'b0;
      bg_offset_run_out <= 1'b0;
      smoothing_on_out <= 1'b0;
      fg_active_out <= 1'b0;
      bg_active_out <= 1'b0;
      offset_adjust_out <= 16'h0000;
      smooth_ctl0_out <= `CRS_RST_OSC0;
      smooth_ctl1_out <= `CRS_RST_OSC1;
      serial_link_enable_out <= 1'b0;
    end else begin
      chan_a_takes_b_out <= !single_mode_in && route_ff[`CRS_BIT_SWAP];
      chan_b_takes_a_out <= !single_mode_in && route_ff[`CRS_BIT_SWAP];
      single_uses_b_out <= single_mode_in && route_ff[1:0] == `CRS_SEL_B;
      single_sel_bad_out <= single_mode_in && route_ff[1:0] != `CRS_SEL_A
                            && route_ff[1:0] != `CRS_SEL_B;
      cal_hold_out <= !run_ff[0] || eng_clr;
      divider_reset_out <= !run_ff[0];
      fg_offset_run_out <= eng_fg && setup_ff[`CRS_BIT_FGOS]
                           && setup_ff[`CRS_BIT_FG];
      bg_offset_run_out <= eng_bg && setup_ff[`CRS_BIT_BGOS]
                           && setup_ff[`CRS_BIT_BG];
      smoothing_on_out <= setup_ff[`CRS_BIT_SMOOTH];
      fg_active_out <= eng_fg;
      bg_active_out <= eng_bg;
      offset_adjust_out <= oadj_ff;
      smooth_ctl0_out <= osc0_ff;
      smooth_ctl1_out <= osc1_ff;
      serial_link_enable_out <= link_ff;
    end
  end
endmodule // crs_top
`default_nettype wire

//--- test/crs_top_properties.sv
`timescale 1ns/1ns
`default_nettype none
module crs_top_properties #(parameter int FG_CYCLES = 1000) (
  // Clock, reset, bus
  input wire mclk_in,
  input wire rst_in,
  input wire wb_cyc_in,
  input wire wb_stb_in,
  input wire wb_ack_out,
  // Routing
  input wire single_mode_in,
  input wire chan_a_takes_b_out,
  input wire chan_b_takes_a_out,
  input wire single_uses_b_out,
  input wire single_sel_bad_out,
  // Calibration
  input wire cal_hold_out,
  input wire divider_reset_out,
  input wire fg_active_out,
  input wire bg_active_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  logic [15:0] fg_cnt_ff;
  always_ff @(posedge mclk_in) begin
    fg_cnt_ff <= (rst_in || !fg_active_out) ? 16'h0000 : fg_cnt_ff + 16'h0001;
  end
  sequence s_take; wb_cyc_in && wb_stb_in && !wb_ack_out; endsequence
  // Mode must settle for the registered routing outputs to follow
  sequence s_single; single_mode_in [*3]; endsequence
  a_ack_answer: assert property (s_take |=> wb_ack_out)
    else $error("no ack after request");
  a_ack_pulse: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("ack longer than one cycle");
  a_swap_pair: assert property (chan_a_takes_b_out == chan_b_takes_a_out)
    else $error("swap halves differ");
  a_swap_single: assert property (s_single |-> !chan_a_takes_b_out)
    else $error("swap active in single mode");
  a_dual_select: assert property ((!single_mode_in) [*3] |-> !(single_uses_b_out || single_sel_bad_out))
    else $error("select active in dual mode");
  a_sel_excl: assert property (!(single_uses_b_out && single_sel_bad_out))
    else $error("select flags both high");
  a_div_hold: assert property (divider_reset_out |-> cal_hold_out)
    else $error("dividers reset without hold");
  a_hold_idle: assert property (divider_reset_out [*3] |-> !fg_active_out && !bg_active_out)
    else $error("calibration runs while held");
  a_phase_excl: assert property (!(fg_active_out && bg_active_out))
    else $error("both passes active");
  a_fg_length: assert property ($fell(fg_active_out) && !divider_reset_out |-> fg_cnt_ff == FG_CYCLES)
    else $error("foreground pass length wrong");
endmodule // crs_top_properties
`default_nettype wire

//--- test/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "crs_regs.vh"
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("[FAIL] %s exp %h got %h", nm, e, g); end end
`define WAITC(c) for (w = 0; w < 200 && !(c); w++) @(posedge mclk_in); \
  if (w == 200) begin num_errors++; report_and_stop(); end
module tb_top;
  logic mclk_in = 0, rst_in = 1, wb_cyc_in = 0, wb_stb_in = 0, wb_we_in = 0;
  logic single_mode_in = 0, bg_halt_in = 0;
  logic [11:0] wb_adr_in = 12'h000;
  logic [3:0] wb_sel_in = 4'h0, sel_v = 4'hF;
  logic [31:0] wb_dat_in = 32'h00000000;
  wire [31:0] wb_dat_out;
  wire wb_ack_out, chan_a_takes_b_out, chan_b_takes_a_out, single_uses_b_out, single_sel_bad_out;
  wire cal_hold_out, divider_reset_out, fg_offset_run_out, bg_offset_run_out, smoothing_on_out;
  wire fg_active_out, bg_active_out, serial_link_enable_out, irq_out;
  wire [15:0] offset_adjust_out;
  wire [7:0] smooth_ctl0_out, smooth_ctl1_out;
  logic [32:0] notes[$];
  logic [32:0] n;
  logic [7:0] r;
  int num_errors = 0, num_checks = 0, seed = 32'h210E8119, i, k, w;
  crs_top #(.FG_CYCLES(10)) DUT (.mclk_in, .rst_in, .wb_cyc_in, .wb_stb_in, .wb_we_in,
    .wb_adr_in, .wb_sel_in, .wb_dat_in, .wb_dat_out, .wb_ack_out, .single_mode_in,
    .bg_halt_in, .chan_a_takes_b_out, .chan_b_takes_a_out, .single_uses_b_out,
    .single_sel_bad_out, .cal_hold_out, .divider_reset_out, .fg_offset_run_out,
    .bg_offset_run_out, .smoothing_on_out, .fg_active_out, .bg_active_out, .offset_adjust_out,
    .smooth_ctl0_out, .smooth_ctl1_out, .serial_link_enable_out, .irq_out);
  initial forever #20 mclk_in = ~mclk_in;
  task automatic report_and_stop();
    if (num_errors == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Each access notes its expected byte; the monitor judges reads only
  task automatic bus(input logic wr, input logic [9:0] idx, input logic [7:0] d, e);
    int t;
    @(posedge mclk_in);
    notes.push_back({~wr, 24'h000000, e});
    wb_cyc_in <= 1'b1;
    wb_stb_in <= 1'b1;
    wb_we_in <= wr;
    wb_sel_in <= sel_v;
    wb_adr_in <= {idx, 2'b00};
    wb_dat_in <= {24'h000000, d};
    for (t = 0; t < 20 && wb_ack_out !== 1'b1; t++) @(posedge mclk_in);
    if (t == 20) begin
      num_errors++;
      report_and_stop();
    end
    wb_cyc_in <= 1'b0;
    wb_stb_in <= 1'b0;
    @(posedge mclk_in);
  endtask
  always @(posedge mclk_in) begin
    if (wb_ack_out === 1'b1) begin
      n = notes.pop_front();
      if (n[32]) `CHK("read", n[31:0], wb_dat_out)
    end
  end
  initial begin
    repeat (2) @(posedge mclk_in);
    rst_in <= 1'b0;
    `WAITC(fg_active_out === 1'b1)
    `WAITC(fg_active_out === 1'b0)
    bus(0, `CRS_IDX_PROG, 8'h00, 8'h03);
    bus(1, `CRS_IDX_PROG, 8'h00, 8'h00);
    bus(0, `CRS_IDX_PROG, 8'h00, 8'h03);
    sel_v = 4'h0;
    bus(1, `CRS_IDX_ROUTE, 8'hFF, 8'h00);
    sel_v = 4'hF;
    bus(0, `CRS_IDX_ROUTE, 8'h00, 8'h01);
    bus(0, `CRS_IDX_RUN, 8'h00, 8'h01);
    bus(0, `CRS_IDX_SETUP, 8'h00, 8'h01);
    bus(0, `CRS_IDX_OSC1, 8'h00, 8'h33);
    `CHK("smooth ctl1", `CRS_RST_OSC1, smooth_ctl1_out)
    bus(0, 10'h3FF, 8'h00, 8'h00);
    `CHK("irq masked", 1'b0, irq_out)
    bus(1, `CRS_IDX_IRQ_MASK, 8'h03, 8'h00);
    repeat (2) @(posedge mclk_in);
    `CHK("irq", 1'b1, irq_out)
    bus(0, `CRS_IDX_IRQ_STAT, 8'h00, 8'h03);
    repeat (2) @(posedge mclk_in);
    `CHK("irq cleared", 1'b0, irq_out)
    bus(1, `CRS_IDX_RUN, 8'h00, 8'h00);
    `CHK("divider", 1'b1, divider_reset_out)
    `CHK("hold", 1'b1, cal_hold_out)
    bus(1, `CRS_IDX_SETUP, 8'h1F, 8'h00);
    bus(1, `CRS_IDX_RUN, 8'h01, 8'h00);
    bus(1, `CRS_IDX_LINK, 8'h01, 8'h00);
    `CHK("link", 1'b1, serial_link_enable_out)
    `WAITC(fg_active_out === 1'b1)
    @(posedge mclk_in);
    `CHK("fg offset", 1'b1, fg_offset_run_out)
    `WAITC(bg_active_out === 1'b1)
    @(posedge mclk_in);
    `CHK("bg offset", 1'b1, bg_offset_run_out)
    `CHK("smoothing", 1'b1, smoothing_on_out)
    bg_halt_in <= 1'b1;
    `WAITC(bg_active_out === 1'b0)
    bus(0, `CRS_IDX_PROG, 8'h00, 8'h03);
    bg_halt_in <= 1'b0;
    `WAITC(bg_active_out === 1'b1)
    bus(0, `CRS_IDX_PROG, 8'h00, 8'h01);
    bus(1, `CRS_IDX_LINK, 8'h00, 8'h00);
    bus(1, `CRS_IDX_RUN, 8'h00, 8'h00);
    bus(1, `CRS_IDX_SETUP, 8'h00, 8'h00);
    bus(1, `CRS_IDX_RUN, 8'h01, 8'h00);
    repeat (8) @(posedge mclk_in);
    bus(0, `CRS_IDX_PROG, 8'h00, 8'h02);
    bus(1, `CRS_IDX_RUN, 8'h00, 8'h00);
    for (i = 0; i < 8; i++) begin
      k = $random(seed);
      r = {k[7:2], i[1:0]};
      single_mode_in <= i[2];
      bus(1, `CRS_IDX_ROUTE, r, 8'h00);
      bus(0, `CRS_IDX_ROUTE, 8'h00, r);
      `CHK("swap", ~i[2] & r[4], chan_a_takes_b_out)
      `CHK("sel b", i[2] & (r[1:0] == 2'h2), single_uses_b_out)
      `CHK("sel bad", i[2] & (r[1:0] == 2'h0 | r[1:0] == 2'h3), single_sel_bad_out)
    end
    k = $random(seed);
    bus(1, `CRS_IDX_OADJ_LO, k[7:0], 8'h00);
    bus(1, `CRS_IDX_OADJ_HI, k[15:8], 8'h00);
    `CHK("offset adj", k[15:0], offset_adjust_out)
    bus(1, `CRS_IDX_OSC0, k[23:16], 8'h00);
    `CHK("smooth ctl0", k[23:16], smooth_ctl0_out)
    report_and_stop();
  end
endmodule // tb_top
bind crs_top crs_top_properties #(.FG_CYCLES(FG_CYCLES)) u_chk (.mclk_in, .rst_in,
  .wb_cyc_in, .wb_stb_in, .wb_ack_out, .single_mode_in, .chan_a_takes_b_out,
  .chan_b_takes_a_out, .single_uses_b_out, .single_sel_bad_out, .cal_hold_out,
  .divider_reset_out, .fg_active_out, .bg_active_out);
`default_nettype wire
